// File: iic_chan_if.sv
`timescale 1ns/1ps
interface iic_chan_if;
  import iic_pkg::*;
  logic          nc;
  logic          ac;
  logic          clr;
  logic [TW-1:0] act_thr;
  logic [TW-1:0] rel_thr;
  logic [DW-1:0] rise_delay;
  logic [DW-1:0] fall_delay;
  logic          status;
  logic [CW-1:0] count;
  logic [VW-1:0] volt;

  modport cfg (output nc, ac, clr, act_thr, rel_thr, rise_delay, fall_delay,
               input status, count, volt);
  modport chan (input nc, ac, clr, act_thr, rel_thr, rise_delay, fall_delay,
                output status, count, volt);
endinterface

// File: iic_channel.sv
`timescale 1ns/1ps
module iic_channel
  import iic_pkg::*;
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          resetn,
  // Scan boundary and measurement
  input  wire logic          scan_tick,
  input  wire logic [VW-1:0] meas_mv,
  // Settings and results
  iic_chan_if.chan           ch
);
  logic          energ_reg;
  logic          status_reg;
  logic [DW:0]   elapsed_reg;
  logic [CW-1:0] count_reg;
  logic [VW-1:0] volt_reg;
  logic          energ_next;
  logic          target;
  logic [DW:0]   dly;
  logic [DW:0]   elapsed_next;
  logic [VW-1:0] act_mv;
  logic [VW-1:0] rel_mv;
  logic [VW-1:0] volt_clip;
  logic          rise_evt;

  assign volt_clip = (meas_mv > VOLT_MAX) ? VOLT_MAX : meas_mv;
  assign act_mv = VW'(ch.act_thr) * THR_TO_MV;
  assign rel_mv = ch.ac ? VW'(ch.act_thr) * AC_REL_MV : VW'(ch.rel_thr) * THR_TO_MV;

  always_comb begin
    energ_next = energ_reg;
    if (volt_clip > act_mv) begin
      energ_next = 1'b1;
    end else if (volt_clip < rel_mv) begin
      energ_next = 1'b0;
    end
  end

  assign target = energ_next ^ ch.nc;

  assign dly = target ? {1'b0, ch.rise_delay}
                      : ({1'b0, ch.fall_delay} + (ch.ac ? AC_EXTRA_MS : '0));
  assign elapsed_next = elapsed_reg + SCAN_STEP_MS;
  assign rise_evt = scan_tick && (target != status_reg) && target && (elapsed_next >= dly);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      energ_reg   <= 1'b0;
      status_reg  <= 1'b0;
      elapsed_reg <= '0;
      volt_reg    <= '0;
    end else if (scan_tick) begin
      energ_reg <= energ_next;
      volt_reg  <= volt_clip;
      if (target != status_reg) begin
        if (elapsed_next >= dly) begin
          status_reg  <= target;
          elapsed_reg <= '0;
        end else begin
          elapsed_reg <= elapsed_next;
        end
      end else begin
        elapsed_reg <= '0;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
    end else if (rise_evt && ch.clr) begin
      count_reg <= CW'(1);
    end else if (rise_evt) begin
      count_reg <= count_reg + 1'b1;
    end else if (ch.clr) begin
      count_reg <= '0;
    end
  end

  assign ch.status = status_reg;
  assign ch.count  = count_reg;
  assign ch.volt   = volt_reg;
endmodule

// File: iic_field_model.sv
`timescale 1ns/1ps
module iic_field_model
  import iic_pkg::*;
(
  // Clock
  input  wire logic                   mclk,
  // Requested plant voltages in mV
  input  wire logic [NCH-1:0][VW-1:0] tgt,
  // Measured voltages towards the block
  output logic [NCH-1:0][VW-1:0]      chan_meas_mv
);
  // Registered like a converter front end, so a change lands one cycle late
  always_ff @(posedge mclk) begin
    chan_meas_mv <= tgt;
  end
endmodule

// File: iic_pkg.sv
package iic_pkg;
  localparam int NCH = 8;
  localparam int VW  = 19;
  localparam int TW  = 12;
  localparam int DW  = 21;
  localparam int CW  = 32;
  localparam int AW  = 12;

  // Thresholds in 0.1 V units, voltages in mV, delays in ms
  localparam logic [TW-1:0] ACT_THR_RST = 12'h0370;
  localparam logic [TW-1:0] REL_THR_RST = 12'h0258;
  localparam logic [TW-1:0] ACT_THR_MIN = 12'h00A0;
  localparam logic [TW-1:0] REL_THR_MIN = 12'h0064;
  localparam logic [TW-1:0] THR_MAX     = 12'h07D0;
  localparam logic [DW-1:0] DLY_RST     = 21'h00_0000;
  localparam logic [DW-1:0] DLY_MAX     = 21'h1B_7740;
  localparam logic [VW-1:0] VOLT_MAX    = 19'h4_3238;
  localparam logic [VW-1:0] THR_TO_MV   = 19'h0_0064;
  localparam logic [VW-1:0] AC_REL_MV   = 19'h0_000A;
  localparam logic [DW:0]   AC_EXTRA_MS = 22'h00_001E;

  localparam int unsigned SCAN_MS     = 5;
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned SCAN_CYCLES_DEF = CLK_HZ / 1000 * SCAN_MS;
  localparam logic [DW:0] SCAN_STEP_MS = 22'(SCAN_MS);

  // Register map
  localparam logic [AW-1:0] OFF_STATUS  = 12'h000;
  localparam logic [3:0]    CH_REGION   = 4'h1;
  localparam logic [2:0]    W_CFG       = 3'h0;
  localparam logic [2:0]    W_ACT       = 3'h1;
  localparam logic [2:0]    W_REL       = 3'h2;
  localparam logic [2:0]    W_RISE      = 3'h3;
  localparam logic [2:0]    W_FALL      = 3'h4;
  localparam logic [2:0]    W_COUNT     = 3'h5;
  localparam logic [2:0]    W_VOLT      = 3'h6;
  localparam int            CFG_NC_BIT  = 0;
  localparam int            CFG_AC_BIT  = 1;
  localparam int            CLR_BIT     = 0;
  localparam logic [1:0]    RESP_OKAY   = 2'h0;
  localparam logic [1:0]    RESP_SLVERR = 2'h2;
endpackage

// File: iic_scan_timer.sv
`timescale 1ns/1ps
module iic_scan_timer #(
  parameter int unsigned CYCLES = 1000
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Scan boundary pulse
  output logic      tick
);
  localparam int CNTW = $clog2(CYCLES + 1);
  localparam logic [CNTW-1:0] LAST = CNTW'(CYCLES - 1);

  logic [CNTW-1:0] cnt_reg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      tick <= (cnt_reg == LAST);
      if (cnt_reg == LAST) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule

// File: iic_top.sv
`timescale 1ns/1ps
// Behaviour
// - Eight independent input channels, all conditioned identically.
// - Channels sampled and updated only on the 5 ms scan boundary, except a counter clear, which applies between scans.
// - Per-channel activation threshold 16.0 to 200.0 V, 0.1 V step, resets 88 V.
// - Per-channel release threshold 10.0 to 200.0 V, 0.1 V step, resets 60 V.
// - Normally open: voltage above activation threshold makes channel active.
// - Normally open: voltage below release threshold makes channel inactive.
// - Normally closed: voltage above activation threshold makes channel inactive.
// - Normally closed: voltage below release threshold makes channel active.
// - Per-channel polarity, default normally open, sets energized logic level.
// - Rising status change delayed 0 to 1800 s in 1 ms steps, default 0.
// - Falling status change delayed 0 to 1800 s in 1 ms steps, default 0.
// - AC mode, default off, adds 30 ms to falling delay.
// - AC mode replaces release threshold with 10 % of activation threshold.
// - 32-bit counter, reset 0, counts each 0-to-1 status change.
// - Software clear command resets that channel's counter to zero, or to 1 when a 0-to-1 status change lands in the same cycle.
// - Live channel voltage reported 0 to 275.000 V in 1 mV steps.
// - Conditioned status reaches internal logic well within one scan.
module iic_top
  import iic_pkg::*;
#(
  parameter int unsigned SCAN_CYCLES = SCAN_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  // Measured channel voltages in mV, from the front-end on mclk
  input  wire logic [NCH-1:0][VW-1:0]  chan_meas_mv,
  // Conditioned channel states
  output logic [NCH-1:0]               input_channel_n,
  // AXI4-Lite write address and data
  input  wire logic [AW-1:0]           s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [CW-1:0]           s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read
  input  wire logic [AW-1:0]           s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [CW-1:0]                s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);
  logic                polarity_nc_reg [NCH];
  logic                alternating_supply_option_reg [NCH];
  logic [TW-1:0]       act_thr_reg [NCH];
  logic [TW-1:0]       rel_thr_reg [NCH];
  logic [DW-1:0]       rise_delay_reg [NCH];
  logic [DW-1:0]       fall_delay_reg [NCH];
  logic [NCH-1:0]      transition_count_clear_reg;
  logic [NCH-1:0]      status_w;
  logic [CW-1:0]       count_w [NCH];
  logic [VW-1:0]       volt_w [NCH];
  logic                scan_tick;
  logic                aw_w_ready_reg;
  logic                ar_ready_reg;
  logic                bvalid_reg;
  logic                rvalid_reg;
  logic [1:0]          bresp_reg;
  logic [1:0]          rresp_reg;
  logic [CW-1:0]       rdata_reg;
  logic [NCH-1:0]      status_out_reg;
  logic                wr_go;
  logic                wr_do;
  logic                rd_go;
  logic                rd_do;
  logic [CW-1:0]       wr_word;
  logic [2:0]          wr_ch;
  logic [2:0]          wr_w;

  function automatic logic addr_mapped(input logic [AW-1:0] a);
    return (a[AW-1:2] == OFF_STATUS[AW-1:2]) ||
           ((a[AW-1:8] == CH_REGION) && (a[4:2] <= W_VOLT));
  endfunction

  // Channel settings live in one region selected by the upper address bits
  function automatic logic chan_hit(input logic [AW-1:0] a);
    return a[AW-1:8] == CH_REGION;
  endfunction

  function automatic logic [TW-1:0] clamp_thr(input logic [CW-1:0] v,
                                              input logic [TW-1:0] lo);
    if (v < CW'(lo)) begin
      return lo;
    end else if (v > CW'(THR_MAX)) begin
      return THR_MAX;
    end
    return v[TW-1:0];
  endfunction

  function automatic logic [DW-1:0] clamp_dly(input logic [CW-1:0] v);
    return (v > CW'(DLY_MAX)) ? DLY_MAX : v[DW-1:0];
  endfunction

  // Counter and voltage words read the live channel results
  function automatic logic [CW-1:0] read_word(input logic [AW-1:0] a);
    logic [2:0] c;
    c = a[7:5];
    if (a[AW-1:2] == OFF_STATUS[AW-1:2]) begin
      return CW'(status_out_reg);
    end else if (a[AW-1:8] != CH_REGION) begin
      return '0;
    end
    case (a[4:2])
      W_CFG:   return CW'({alternating_supply_option_reg[c], polarity_nc_reg[c]});
      W_ACT:   return CW'(act_thr_reg[c]);
      W_REL:   return CW'(rel_thr_reg[c]);
      W_RISE:  return CW'(rise_delay_reg[c]);
      W_FALL:  return CW'(fall_delay_reg[c]);
      W_COUNT: return count_w[c];
      W_VOLT:  return CW'(volt_w[c]);
      default: return '0;
    endcase
  endfunction

  // Byte strobes merge into the current value before clamping
  function automatic logic [CW-1:0] merge(input logic [CW-1:0] old_v,
                                          input logic [CW-1:0] new_v,
                                          input logic [3:0]    strb);
    logic [CW-1:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  iic_scan_timer #(
    .CYCLES (SCAN_CYCLES)
  ) u_scan (
    .mclk   (mclk),
    .resetn (resetn),
    .tick   (scan_tick)
  );

  iic_chan_if chif [NCH] ();

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    assign chif[g].nc         = polarity_nc_reg[g];
    assign chif[g].ac         = alternating_supply_option_reg[g];
    assign chif[g].clr        = transition_count_clear_reg[g];
    assign chif[g].act_thr    = act_thr_reg[g];
    assign chif[g].rel_thr    = rel_thr_reg[g];
    assign chif[g].rise_delay = rise_delay_reg[g];
    assign chif[g].fall_delay = fall_delay_reg[g];
    assign status_w[g]        = chif[g].status;
    assign count_w[g]         = chif[g].count;
    assign volt_w[g]          = chif[g].volt;

    iic_channel u_ch (
      .mclk      (mclk),
      .resetn    (resetn),
      .scan_tick (scan_tick),
      .meas_mv   (chan_meas_mv[g]),
      .ch        (chif[g])
    );
  end

  // Write address and data are taken together; bvalid blocks a second write
  assign wr_go   = s_axi_awvalid && s_axi_wvalid && !aw_w_ready_reg && !bvalid_reg;
  assign wr_do   = aw_w_ready_reg && s_axi_awvalid && s_axi_wvalid;
  assign rd_go   = s_axi_arvalid && !ar_ready_reg && !rvalid_reg;
  assign rd_do   = ar_ready_reg && s_axi_arvalid;
  // A process, not an assign: read_word reads registers that are not its arguments
  always_comb begin
    wr_word = merge(read_word(s_axi_awaddr), s_axi_wdata, s_axi_wstrb);
  end
  assign wr_ch   = s_axi_awaddr[7:5];
  assign wr_w    = s_axi_awaddr[4:2];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_w_ready_reg <= 1'b0;
      bvalid_reg     <= 1'b0;
      bresp_reg      <= RESP_OKAY;
    end else begin
      aw_w_ready_reg <= wr_go;
      if (wr_do) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= addr_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ar_ready_reg <= 1'b0;
      rvalid_reg   <= 1'b0;
      rresp_reg    <= RESP_OKAY;
      rdata_reg    <= '0;
    end else begin
      ar_ready_reg <= rd_go;
      if (rd_do) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= read_word(s_axi_araddr);
        rresp_reg  <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        polarity_nc_reg[i]               <= 1'b0;
        alternating_supply_option_reg[i] <= 1'b0;
      end
    end else if (wr_do && chan_hit(s_axi_awaddr) && (wr_w == W_CFG)) begin
      polarity_nc_reg[wr_ch]               <= wr_word[CFG_NC_BIT];
      alternating_supply_option_reg[wr_ch] <= wr_word[CFG_AC_BIT];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        act_thr_reg[i] <= ACT_THR_RST;
        rel_thr_reg[i] <= REL_THR_RST;
      end
    end else if (wr_do && chan_hit(s_axi_awaddr)) begin
      if (wr_w == W_ACT) begin
        act_thr_reg[wr_ch] <= clamp_thr(wr_word, ACT_THR_MIN);
      end
      if (wr_w == W_REL) begin
        rel_thr_reg[wr_ch] <= clamp_thr(wr_word, REL_THR_MIN);
      end
    end
  end

  // delays with range clamp
  // Oversize values clamp to full scale instead of being refused
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        rise_delay_reg[i] <= DLY_RST;
        fall_delay_reg[i] <= DLY_RST;
      end
    end else if (wr_do && chan_hit(s_axi_awaddr)) begin
      if (wr_w == W_RISE) begin
        rise_delay_reg[wr_ch] <= clamp_dly(wr_word);
      end
      if (wr_w == W_FALL) begin
        fall_delay_reg[wr_ch] <= clamp_dly(wr_word);
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      transition_count_clear_reg <= '0;
    end else begin
      transition_count_clear_reg <= '0;
      if (wr_do && (s_axi_awaddr[AW-1:8] == CH_REGION) && (wr_w == W_COUNT) &&
          s_axi_wstrb[0] && s_axi_wdata[CLR_BIT]) begin
        transition_count_clear_reg[wr_ch] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status_out_reg <= '0;
    end else begin
      status_out_reg <= status_w;
    end
  end

  assign input_channel_n = status_out_reg;
  assign s_axi_awready   = aw_w_ready_reg;
  assign s_axi_wready    = aw_w_ready_reg;
  assign s_axi_bvalid    = bvalid_reg;
  assign s_axi_bresp     = bresp_reg;
  assign s_axi_arready   = ar_ready_reg;
  assign s_axi_rvalid    = rvalid_reg;
  assign s_axi_rdata     = rdata_reg;
  assign s_axi_rresp     = rresp_reg;
endmodule

// File: iic_top_sva.sv
`timescale 1ns/1ps
module iic_top_sva
  import iic_pkg::*;
(
  // Clock and reset
  input wire logic           mclk,
  input wire logic           resetn,
  // Channel states
  input wire logic [NCH-1:0] input_channel_n,
  // Write side
  input wire logic           s_axi_awvalid,
  input wire logic           s_axi_awready,
  input wire logic           s_axi_wvalid,
  input wire logic           s_axi_wready,
  input wire logic [1:0]     s_axi_bresp,
  input wire logic           s_axi_bvalid,
  input wire logic           s_axi_bready,
  // Read side
  input wire logic           s_axi_arvalid,
  input wire logic           s_axi_arready,
  input wire logic [CW-1:0]  s_axi_rdata,
  input wire logic           s_axi_rvalid,
  input wire logic           s_axi_rready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // States move only on scan boundaries, never twice in a row
  a_scan_only: assert property ($changed(input_channel_n) |=> $stable(input_channel_n)[*8])
    else $error("channel state changed between scans");
  a_wr_answer: assert property (s_wr_taken |=> s_axi_bvalid)
    else $error("no write response after transfer");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("no read data after transfer");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_aw_pair: assert property (s_axi_awready == s_axi_wready)
    else $error("address and data ready differ");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write ready longer than one cycle");
  a_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken with response pending");
  a_r_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken with data pending");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
endmodule

// File: iic_top_tb.sv
`timescale 1ns/1ps
module iic_top_tb;
  import iic_pkg::*;
  localparam int SC = 20;
  localparam logic [CW-1:0] RST_EXP [7] = '{32'h0000_0000, CW'(ACT_THR_RST), CW'(REL_THR_RST),
    CW'(DLY_RST), CW'(DLY_RST), 32'h0000_0000, 32'h0000_0000};
  localparam logic [CW-1:0] CLAMP_EXP [4] = '{CW'(ACT_THR_MIN), CW'(REL_THR_MIN),
    CW'(DLY_MAX), CW'(DLY_MAX)};
  logic                   mclk, resetn;
  logic [NCH-1:0][VW-1:0] chan_meas_mv, tgt;
  logic [NCH-1:0]         input_channel_n, en_m, st_m, nc_m;
  logic [AW-1:0]          s_axi_awaddr, s_axi_araddr;
  logic [CW-1:0]          s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]             s_axi_wstrb;
  logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                   s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                   s_axi_rvalid, s_axi_rready, en_n;
  logic [1:0]             s_axi_bresp, s_axi_rresp;
  logic [CW-1:0]          cnt_m [NCH];
  logic [VW-1:0]          v;
  int                     errors, n_compared, c;

  iic_top #(.SCAN_CYCLES(SC)) i_dut (.mclk, .resetn, .chan_meas_mv, .input_channel_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  iic_field_model i_field (.mclk, .tgt, .chan_meas_mv);

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string nm, input logic [CW-1:0] seen, input logic [CW-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bound(input logic ok);
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH handshake expected 1 seen 0");
      test_done();
    end
  endtask

  function automatic logic [AW-1:0] ra(input int ch, input logic [2:0] w);
    return {CH_REGION, 3'(ch), w, 2'b00};
  endfunction

  // Hysteresis: between the two thresholds the old state holds
  function automatic logic nxt(input logic en, input logic [VW-1:0] mv);
    if (mv > 19'd88000) return 1'b1;
    if (mv < 19'd60000) return 1'b0;
    return en;
  endfunction

  function automatic logic [VW-1:0] pick();
    case ($urandom % 5)
      0: return 19'd88000;
      1: return 19'd60000;
      2: return VW'(88001 + $urandom % 187000);
      3: return VW'(60001 + $urandom % 27999);
      default: return VW'($urandom % 60000);
    endcase
  endfunction

  task automatic axi_wr(input logic [AW-1:0] a, input logic [CW-1:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    n = 0;
    do begin @(posedge mclk); n++; end while (s_axi_awready !== 1'b1 && n < 50);
    bound(s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    repeat ($urandom % 3) @(posedge mclk);
    s_axi_bready <= 1'b1;
    n = 0;
    do begin @(posedge mclk); n++; end while (s_axi_bvalid !== 1'b1 && n < 50);
    bound(s_axi_bvalid);
    check("bresp", CW'(s_axi_bresp), CW'(er));
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [AW-1:0] a, input logic [1:0] er);
    int n;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin @(posedge mclk); n++; end while (s_axi_arready !== 1'b1 && n < 50);
    bound(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom % 3) @(posedge mclk);
    s_axi_rready <= 1'b1;
    n = 0;
    do begin @(posedge mclk); n++; end while (s_axi_rvalid !== 1'b1 && n < 50);
    bound(s_axi_rvalid);
    rd = s_axi_rdata;
    check("rresp", CW'(s_axi_rresp), CW'(er));
    s_axi_rready <= 1'b0;
  endtask

  initial begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    tgt = '0;
    errors = 0;
    n_compared = 0;
    void'($urandom(48));
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    c = $urandom % NCH;
    for (int w = 0; w < 7; w++) begin
      axi_rd(ra(c, 3'(w)), RESP_OKAY);
      check("reset value", rd, RST_EXP[w]);
    end
    axi_rd(ra(c, 3'h7), RESP_SLVERR);
    check("unmapped read", rd, 32'h0000_0000);
    axi_wr(ra(c, 3'h7), 32'h0000_0001, RESP_SLVERR);
    axi_wr(OFF_STATUS, 32'h0000_00FF, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      axi_wr(ra(c, 3'(k + 1)), (k < 2) ? 32'h0000_0000 : 32'hFFFF_FFFF, RESP_OKAY);
      axi_rd(ra(c, 3'(k + 1)), RESP_OKAY);
      check("clamped setting", rd, CLAMP_EXP[k]);
      axi_wr(ra(c, 3'(k + 1)), RST_EXP[k + 1], RESP_OKAY);
    end
    // Only byte 1 may land; the other bytes keep the current value
    s_axi_wstrb <= 4'h2;
    axi_wr(ra(c, W_FALL), 32'hFFFF_12FF, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_rd(ra(c, W_FALL), RESP_OKAY);
    check("strobed write", rd, 32'h0000_1200);
    axi_wr(ra(c, W_FALL), 32'h0000_0000, RESP_OKAY);
    $display("test reset and settings done");
    // Polarity chosen per channel; counters cleared once the states settle
    nc_m = NCH'($urandom);
    for (int i = 0; i < NCH; i++) axi_wr(ra(i, W_CFG), CW'(nc_m[i]), RESP_OKAY);
    repeat (3 * SC) @(posedge mclk);
    for (int i = 0; i < NCH; i++) begin
      axi_wr(ra(i, W_COUNT), 32'h0000_0001, RESP_OKAY);
      axi_rd(ra(i, W_COUNT), RESP_OKAY);
      check("cleared count", rd, 32'h0000_0000);
      cnt_m[i] = '0;
    end
    en_m = '0;
    st_m = nc_m;
    for (int it = 0; it < 12; it++) begin
      for (int i = 0; i < NCH; i++) begin
        v = pick();
        tgt[i] <= v;
        en_n = nxt(en_m[i], v);
        if ((en_n ^ nc_m[i]) && !st_m[i]) cnt_m[i]++;
        en_m[i] = en_n;
        st_m[i] = en_n ^ nc_m[i];
      end
      repeat (2 * SC + 2) @(posedge mclk);
      check("states", CW'(input_channel_n), CW'(st_m));
      axi_rd(OFF_STATUS, RESP_OKAY);
      check("status word", rd, CW'(st_m));
      c = $urandom % NCH;
      axi_rd(ra(c, W_COUNT), RESP_OKAY);
      check("count", rd, cnt_m[c]);
      axi_rd(ra(c, W_VOLT), RESP_OKAY);
      check("voltage", rd, CW'(tgt[c]));
    end
    $display("test hysteresis done");
    axi_wr(ra(0, W_CFG), 32'h0000_0002, RESP_OKAY);
    axi_wr(ra(1, W_CFG), 32'h0000_0000, RESP_OKAY);
    axi_wr(ra(1, W_RISE), 32'h0000_000C, RESP_OKAY);
    axi_wr(ra(1, W_FALL), 32'h0000_0007, RESP_OKAY);
    tgt[0] <= 19'd100000;
    tgt[1] <= 19'd0;
    repeat (3 * SC) @(posedge mclk);
    // Below the normal release level but above a tenth of activation
    tgt[0] <= 19'd9000;
    tgt[1] <= 19'd100000;
    repeat (SC) @(posedge mclk);
    check("ac hold", CW'(input_channel_n[1:0]), 32'h0000_0001);
    tgt[0] <= 19'd8000;
    tgt[1] <= 19'd0;
    repeat (SC) @(posedge mclk);
    tgt[1] <= 19'd100000;
    repeat (2 * SC) @(posedge mclk);
    check("delays pending", CW'(input_channel_n[1:0]), 32'h0000_0001);
    repeat (5 * SC) @(posedge mclk);
    check("delays expired", CW'(input_channel_n[1:0]), 32'h0000_0002);
    tgt[1] <= 19'd0;
    repeat (SC) @(posedge mclk);
    check("fall pending", CW'(input_channel_n[1]), 32'h0000_0001);
    repeat (2 * SC) @(posedge mclk);
    check("fall expired", CW'(input_channel_n[1]), 32'h0000_0000);
    // Above full scale the reported voltage sticks at the top of range
    tgt[2] <= 19'h7_FFFF;
    repeat (2 * SC) @(posedge mclk);
    axi_rd(ra(2, W_VOLT), RESP_OKAY);
    check("voltage clip", rd, CW'(VOLT_MAX));
    $display("test delays done");
    test_done();
  end
endmodule

bind iic_top iic_top_sva i_sva (.mclk, .resetn, .input_channel_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
